// [core/adcsq_core.sv]
/*
  Sequencer and register file of an eight-input converter: four modes
  (one channel or four-channel scan, once or repeating), sampling delay,
  completion and overrun flags, result pointer and interrupt level.
  Assumes the converter core runs on i_clk and holds a valid result on
  i_conv_result by the tenth converter tick after o_conv_start.
*/
`timescale 1ns/100ps

// Overview of operation
// R1: Software stops start, waits busy low, disables
// R2: Keep enabled for idle under 100 us
// R3: Sampling delay before every conversion
// R4: Each conversion lasts ten converter ticks
// R5: Completion flag set on results, cleared by read
// R6: Two-bit index of last written result
// R7: Interrupt level equals completion flag when enabled
// R8: Any result read drops the interrupt; the code keeps it when a completion sets the flag in the same cycle
// R9: Interrupt drives the fifth controller input line
// R10: Overrun overwrites result and sets overrun flag
// R11: Overrun flag cleared only by writing one; the code also clears it on disable
// R12: Software changes mode only when idle
// R13: Scan steps channels upward modulo eight
// R14: Single conversion fills result zero, clears start
// R15: Repeat single channel fills results cyclically
// R16: Clearing start finishes current conversion, stops
// R17: Single scan converts four channels then stops
// R18: Repeat scan bursts until start cleared
// R19: Four control registers and four results
// R20: Start rising loads result index three
// R21: Disable aborts and clears flags and start
// R22: Busy high only while converting; the code also holds it high through the sampling delay
// R23: Mode fields start7 scan5 repeat4 channel2-0
// R24: Core gets start pulse, channel; returns result
// R25: Prescaler strobe paces all sequencing counters
module adcsq_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Converter core
  output logic o_conv_start,
  output logic [2:0] o_conv_channel,
  input wire logic [7:0] i_conv_result,
  output logic o_core_power,
  output logic o_ref_power,
  // Interrupt controller
  output logic o_converter_irq_line
);

  function automatic logic is_result(input logic [2:0] a);
    return a >= adcsq_pkg::OFS_RESULT0;
  endfunction

  function automatic logic [5:0] div_mask(input logic [2:0] c);
    logic [2:0] s;
    s = (c > adcsq_pkg::CDIV_MAX) ? adcsq_pkg::CDIV_MAX : c;
    return 6'((7'h01 << s) - 7'h01);
  endfunction

  logic converter_enable;
  logic intref;
  logic irq_enable;
  logic start;
  logic scan;
  logic repeat_mode;
  logic [2:0] channel;
  logic [2:0] delay;
  logic [2:0] cdiv;
  logic eoc;
  logic ovf;
  logic [1:0] last_result_index;
  logic [3:0] full;
  adcsq_pkg::adcsq_state_type state;
  logic [3:0] cnt;
  logic [5:0] pre_cnt;
  logic [2:0] cur_chan;
  logic [7:0] reg_q;
  logic rd_mem;
  logic [7:0] mem_q;
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] mode_byte;
  logic [7:0] timing_byte;
  logic tick;
  logic busy;
  logic [1:0] wr_idx;
  logic complete;
  logic run_on;
  logic set_eoc;
  logic stop_in_sample;
  logic wr_ctrl1;
  logic wr_mode;
  logic wr_timing;
  logic wr_status;
  logic rd_result;
  logic start_rise;
  logic disable_now;
  adcsq_pkg::adcsq_res_wr_type res_wr;

  assign wr_ctrl1 = i_wr && (i_addr == adcsq_pkg::OFS_CONTROL_ONE);
  assign wr_mode = i_wr && (i_addr == adcsq_pkg::OFS_MODE);
  assign wr_timing = i_wr && (i_addr == adcsq_pkg::OFS_TIMING);
  assign wr_status = i_wr && (i_addr == adcsq_pkg::OFS_STATUS);
  assign rd_result = i_rd && is_result(i_addr);
  assign disable_now = wr_ctrl1 && !i_wdata[adcsq_pkg::C1_EN];
  assign start_rise = wr_mode && i_wdata[adcsq_pkg::MD_START] && !start && converter_enable;

  // Converter clock is a strobe, so the whole block stays on one clock [R25]
  assign tick = converter_enable && ((pre_cnt & div_mask(cdiv)) == div_mask(cdiv));
  assign busy = (state != adcsq_pkg::ST_IDLE); // [R22]
  assign wr_idx = last_result_index + 2'h1;
  assign complete = (state == adcsq_pkg::ST_CONVERT) && tick && (cnt == adcsq_pkg::CONV_LAST);
  assign stop_in_sample = (state == adcsq_pkg::ST_SAMPLE) && !start && !scan && !disable_now
                          && !start_rise;

  // Whether another conversion follows the one now completing
  always_comb begin
    if (scan) begin
      run_on = (wr_idx != adcsq_pkg::PTR_LAST) || (repeat_mode && start); // [R17] [R18]
    end else begin
      run_on = repeat_mode && start; // [R14] [R15] [R16]
    end
  end

  always_comb begin
    if (scan) begin
      set_eoc = complete && (wr_idx == adcsq_pkg::PTR_LAST); // [R17] [R18]
    end else begin
      set_eoc = complete && (!repeat_mode || !start || (wr_idx == adcsq_pkg::PTR_LAST)); // [R15]
    end
    set_eoc = set_eoc || stop_in_sample; // [R16]
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt <= adcsq_pkg::RST_PRESCALE;
    end else if (!converter_enable) begin
      pre_cnt <= adcsq_pkg::RST_PRESCALE;
    end else begin
      pre_cnt <= pre_cnt + 6'h01; // [R25]
    end
  end

  // Sequencer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= adcsq_pkg::ST_IDLE;
      cnt <= 4'h0;
      cur_chan <= adcsq_pkg::RST_FIELD3;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (disable_now) begin
        state <= adcsq_pkg::ST_IDLE; // [R21]
        cnt <= 4'h0;
      end else if (start_rise) begin
        state <= adcsq_pkg::ST_SAMPLE; // [R3]
        cnt <= 4'h0;
        cur_chan <= i_wdata[adcsq_pkg::MD_CHAN_LO +: 3];
      end else begin
        unique case (state)
          adcsq_pkg::ST_IDLE: begin
            cnt <= 4'h0;
          end
          adcsq_pkg::ST_SAMPLE: begin
            if (!start && !scan) begin
              state <= adcsq_pkg::ST_IDLE; // [R16]
            end else if (tick) begin
              if (cnt == {1'b0, delay}) begin
                state <= adcsq_pkg::ST_CONVERT; // [R3]
                cnt <= 4'h0;
                o_conv_start <= 1'b1; // [R24]
              end else begin
                cnt <= cnt + 4'h1;
              end
            end
          end
          adcsq_pkg::ST_CONVERT: begin
            if (tick) begin
              if (cnt == adcsq_pkg::CONV_LAST) begin
                cnt <= 4'h0; // [R4]
                state <= run_on ? adcsq_pkg::ST_SAMPLE : adcsq_pkg::ST_IDLE;
                if (scan) begin
                  // A new burst begins again from the first channel
                  cur_chan <= (wr_idx == adcsq_pkg::PTR_LAST) ? channel
                              : cur_chan + 3'h1; // [R13]
                end
              end else begin
                cnt <= cnt + 4'h1; // [R4]
              end
            end
          end
          default: begin
            state <= adcsq_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Software-owned configuration
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      converter_enable <= 1'b0;
      intref <= 1'b0;
      irq_enable <= 1'b0;
      delay <= adcsq_pkg::RST_FIELD3;
      cdiv <= adcsq_pkg::RST_FIELD3;
    end else begin
      if (wr_ctrl1) begin
        converter_enable <= i_wdata[adcsq_pkg::C1_EN];
        intref <= i_wdata[adcsq_pkg::C1_INTREF];
        irq_enable <= i_wdata[adcsq_pkg::C1_IRQEN];
      end
      if (wr_timing) begin
        delay <= i_wdata[adcsq_pkg::TM_DELAY_LO +: 3];
        cdiv <= i_wdata[adcsq_pkg::TM_CDIV_LO +: 3];
      end
    end
  end

  // Mode register; mode fields are trusted to change only while idle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start <= 1'b0;
      scan <= 1'b0;
      repeat_mode <= 1'b0;
      channel <= adcsq_pkg::RST_FIELD3;
    end else begin
      if (wr_mode) begin
        scan <= i_wdata[adcsq_pkg::MD_SCAN]; // [R23]
        repeat_mode <= i_wdata[adcsq_pkg::MD_REPEAT];
        channel <= i_wdata[adcsq_pkg::MD_CHAN_LO +: 3];
      end
      if (disable_now) begin
        start <= 1'b0; // [R21]
      end else if (wr_mode) begin
        start <= i_wdata[adcsq_pkg::MD_START] && converter_enable;
      end else if (complete && !repeat_mode && !run_on) begin
        start <= 1'b0; // [R14] [R17]
      end
    end
  end

  // Status flags; a hardware set wins over a read or write-one clear in the same cycle, a disable wins over both
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eoc <= 1'b0;
      ovf <= 1'b0;
      last_result_index <= adcsq_pkg::RST_PTR;
    end else begin
      if (disable_now) begin
        eoc <= 1'b0; // [R21]
      end else if (set_eoc) begin
        eoc <= 1'b1; // [R5]
      end else if (rd_result) begin
        eoc <= 1'b0; // [R5] [R8]
      end
      if (disable_now) begin
        ovf <= 1'b0; // [R21]
      end else if (complete && full[wr_idx]) begin
        ovf <= 1'b1; // [R10]
      end else if (wr_status && i_wdata[adcsq_pkg::ST_OVF]) begin
        ovf <= 1'b0; // [R11]
      end
      if (start_rise) begin
        last_result_index <= adcsq_pkg::PTR_ON_START; // [R20]
      end else if (complete) begin
        last_result_index <= wr_idx; // [R6]
      end
    end
  end

  // Unread-result markers, one per result register
  for (genvar i = 0; i < 4; i++) begin : g_full
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        full[i] <= 1'b0;
      end else if (disable_now) begin
        full[i] <= 1'b0;
      end else if (complete && (wr_idx == 2'(i))) begin
        full[i] <= 1'b1; // [R10]
      end else if (rd_result && (i_addr[1:0] == 2'(i))) begin
        full[i] <= 1'b0;
      end
    end
  end

  assign res_wr = '{en: complete, idx: wr_idx, data: i_conv_result};

  adcsq_result_mem u_results (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_wr(res_wr),
    .i_rd_en(rd_result),
    .i_rd_idx(i_addr[1:0]),
    .o_rd_data(mem_q)
  );

  always_comb begin
    status_byte = adcsq_pkg::RST_BYTE;
    status_byte[adcsq_pkg::ST_EOC] = eoc;
    status_byte[adcsq_pkg::ST_BUSY] = busy;
    status_byte[adcsq_pkg::ST_OVF] = ovf;
    status_byte[adcsq_pkg::ST_PTR_LO +: 2] = last_result_index;
    ctrl_byte = adcsq_pkg::RST_BYTE;
    ctrl_byte[adcsq_pkg::C1_EN] = converter_enable;
    ctrl_byte[adcsq_pkg::C1_INTREF] = intref;
    ctrl_byte[adcsq_pkg::C1_IRQEN] = irq_enable;
    mode_byte = adcsq_pkg::RST_BYTE;
    mode_byte[adcsq_pkg::MD_START] = start;
    mode_byte[adcsq_pkg::MD_SCAN] = scan;
    mode_byte[adcsq_pkg::MD_REPEAT] = repeat_mode;
    mode_byte[adcsq_pkg::MD_CHAN_LO +: 3] = channel;
    timing_byte = adcsq_pkg::RST_BYTE;
    timing_byte[adcsq_pkg::TM_DELAY_LO +: 3] = delay;
    timing_byte[adcsq_pkg::TM_CDIV_LO +: 3] = cdiv;
  end

  // Read data stand one cycle after the strobe [R19]
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_q <= adcsq_pkg::RST_BYTE;
      rd_mem <= 1'b0;
    end else begin
      rd_mem <= rd_result;
      if (i_rd) begin
        unique case (i_addr)
          adcsq_pkg::OFS_STATUS: reg_q <= status_byte;
          adcsq_pkg::OFS_CONTROL_ONE: reg_q <= ctrl_byte;
          adcsq_pkg::OFS_MODE: reg_q <= mode_byte;
          adcsq_pkg::OFS_TIMING: reg_q <= timing_byte;
          default: reg_q <= adcsq_pkg::RST_BYTE;
        endcase
      end
    end
  end

  assign o_rdata = rd_mem ? mem_q : reg_q;
  assign o_conv_channel = cur_chan;
  assign o_core_power = converter_enable;
  assign o_ref_power = converter_enable && intref;
  assign o_converter_irq_line = irq_enable && eoc; // [R7] [R9]

  // Checks
  logic [3:0] conv_ticks_h;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_ticks_h <= 4'h0;
    end else if (o_conv_start) begin
      // At the undivided rate the start cycle is itself the first converting tick
      conv_ticks_h <= {3'h0, tick};
    end else if ((state == adcsq_pkg::ST_CONVERT) && tick) begin
      conv_ticks_h <= conv_ticks_h + 4'h1;
    end
  end

  sequence s_single_done;
    !start && eoc && (state == adcsq_pkg::ST_IDLE);
  endsequence

  sequence s_aborted;
    (state == adcsq_pkg::ST_IDLE) && !start && !eoc && !ovf;
  endsequence

  property p_conv_len;
    @(posedge i_clk) disable iff (!i_arst_n) complete |-> conv_ticks_h == adcsq_pkg::CONV_LAST;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R4]

  property p_ptr_load;
    @(posedge i_clk) disable iff (!i_arst_n) start_rise |=> last_result_index == 2'h3 && busy;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // [R20]

  property p_irq_drop;
    @(posedge i_clk) disable iff (!i_arst_n)
      rd_result && !set_eoc && !disable_now |=> !o_converter_irq_line;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped"); // [R8]

  property p_irq_rise;
    @(posedge i_clk) disable iff (!i_arst_n)
      set_eoc && irq_enable && !wr_ctrl1 |=> o_converter_irq_line;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq not raised"); // [R7]

  property p_ovf_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      complete && full[wr_idx] && !disable_now |=> ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overrun missed"); // [R10]

  property p_ovf_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
      ovf && !disable_now && !(wr_status && i_wdata[adcsq_pkg::ST_OVF]) |=> ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overrun lost"); // [R11]

  property p_single_done;
    @(posedge i_clk) disable iff (!i_arst_n)
      complete && !scan && !repeat_mode && !i_wr |=> s_single_done;
  endproperty
  a_single_done: assert property (p_single_done) else $error("single end wrong"); // [R14]

  property p_scan_step;
    @(posedge i_clk) disable iff (!i_arst_n)
      complete && scan && (wr_idx != 2'h3) && !i_wr |=> cur_chan == $past(cur_chan) + 3'h1;
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan step wrong"); // [R13]

  property p_abort;
    @(posedge i_clk) disable iff (!i_arst_n) disable_now |=> s_aborted ##1 !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("disable incomplete"); // [R21]

endmodule

// [core/adcsq_pkg.sv]
/*
  Shared constants and types for the converter sequencer: register indices,
  field positions, reset values, sequencing counts, states and carriers.
  Assumes an 8-bit register port with a 3-bit register index.
*/
package adcsq_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register indices on the register port
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_CONTROL_ONE = 3'h1;
  localparam logic [2:0] OFS_MODE = 3'h2;
  localparam logic [2:0] OFS_TIMING = 3'h3;
  localparam logic [2:0] OFS_RESULT0 = 3'h4;

  // Status register fields
  localparam int ST_EOC = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_OVF = 2;
  localparam int ST_PTR_LO = 4;

  // Control register one fields
  localparam int C1_EN = 0;
  localparam int C1_INTREF = 1;
  localparam int C1_IRQEN = 2;

  // Mode register fields
  localparam int MD_CHAN_LO = 0;
  localparam int MD_REPEAT = 4;
  localparam int MD_SCAN = 5;
  localparam int MD_START = 7;

  // Timing register fields
  localparam int TM_CDIV_LO = 0;
  localparam int TM_DELAY_LO = 3;

  // Values after reset and on start
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PTR = 2'h0;
  localparam logic [1:0] PTR_ON_START = 2'h3;
  localparam logic [1:0] PTR_LAST = 2'h3;
  localparam logic [2:0] RST_FIELD3 = 3'h0;
  localparam logic [5:0] RST_PRESCALE = 6'h00;

  // Sequencing counts in converter clock ticks
  localparam logic [3:0] CONV_TICKS = 4'ha;
  localparam logic [3:0] CONV_LAST = CONV_TICKS - 4'h1;
  localparam logic [2:0] CDIV_MAX = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcsq_state_type;

  typedef struct packed {
    logic en;
    logic [1:0] idx;
    logic [7:0] data;
  } adcsq_res_wr_type;

endpackage

// [core/adcsq_result_mem.sv]
/*
  Four-entry result store with one write port and a registered read port.
  Assumes writes and reads come from logic on the same clock.
*/
`timescale 1ns/100ps
module adcsq_result_mem (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Write side
  input wire adcsq_pkg::adcsq_res_wr_type i_wr,
  // Read side
  input wire logic i_rd_en,
  input wire logic [1:0] i_rd_idx,
  output logic [7:0] o_rd_data
);

  logic [7:0] mem [0:3];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] <= adcsq_pkg::RST_BYTE;
      end
    end else if (i_wr.en) begin
      mem[i_wr.idx] <= i_wr.data;
    end
  end

  // A read in the same cycle as a write to the same entry returns the old value
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= adcsq_pkg::RST_BYTE;
    end else if (i_rd_en) begin
      o_rd_data <= mem[i_rd_idx];
    end
  end

endmodule

// [verification/adcsq_conv_model.sv]
/*
  Behavioural converter core facing the sequencer's converter port.
  Assumes start is a one-cycle pulse on i_clk and that the sequencer
  samples the result no earlier than ten converter ticks after it.
*/
`timescale 1ns/100ps
module adcsq_conv_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Sequencer side
  input wire logic i_start,
  input wire logic [2:0] i_channel,
  input wire logic i_slow,
  output logic [7:0] o_result
);
  logic [3:0] wait_cnt;
  logic [7:0] value;
  logic [4:0] seq;

  // Result is the channel plus a running count, ready 1 or 8 clocks after start;
  // until then the line toggles so an early sample never matches
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt <= 4'h0;
      value <= 8'h00;
      seq <= 5'h00;
      o_result <= 8'hff;
    end else if (i_start) begin
      seq <= seq + 5'h01;
      value <= {i_channel, seq + 5'h01};
      wait_cnt <= i_slow ? 4'h8 : 4'h1;
      o_result <= ~o_result;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      o_result <= (wait_cnt == 4'h1) ? value : ~o_result;
    end
  end
endmodule

// [verification/adcsq_core_test.sv]
/*
  Self-checking bench for the converter sequencer: register port master,
  converter core model and a monitor of starts and interrupt edges.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
module adcsq_core_test;
  logic i_clk;
  logic i_arst_n;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic o_conv_start;
  logic [2:0] o_conv_channel;
  logic [7:0] i_conv_result;
  logic o_core_power;
  logic o_ref_power;
  logic o_converter_irq_line;
  logic slow;
  logic irq_d;
  logic [7:0] s;
  logic [2:0] ch;
  logic [2:0] dly;
  logic [2:0] ch_q[$];
  int num_errors;
  int n_checks;
  int n_conv;
  int base;
  int c;
  int lat0;
  time t_wr;
  time t_go;
  time t_irq;

  adcsq_core u_adcsq_core (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel),
    .i_conv_result(i_conv_result), .o_core_power(o_core_power),
    .o_ref_power(o_ref_power), .o_converter_irq_line(o_converter_irq_line));
  adcsq_conv_model u_adcsq_conv_model (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_start(o_conv_start), .i_channel(o_conv_channel), .i_slow(slow),
    .o_result(i_conv_result));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_conv_start === 1'b1) begin
      n_conv++;
      t_go = $time;
      ch_q.push_back(o_conv_channel);
    end
    if (o_converter_irq_line === 1'b1 && irq_d !== 1'b1)
      t_irq = $time;
    irq_d = o_converter_irq_line;
  end

  function automatic logic [2:0] nx(input logic [2:0] b, input int k);
    return b + k[2:0];
  endfunction

  function automatic logic [7:0] exp_res(input logic [2:0] b, input int seq);
    return {b, seq[4:0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", nm);
    end_of_test();
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Each access leaves one idle cycle so a strobe is never driven twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    t_wr = $time;
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  task automatic waitirq();
    for (int i = 0; i < 3000; i++) begin
      if (o_converter_irq_line === 1'b1) begin
        @(negedge i_clk);
        @(posedge i_clk);
        return;
      end
      @(posedge i_clk);
    end
    tmo("irq");
  endtask

  task automatic poll_idle();
    logic [7:0] st;
    logic [7:0] md;
    for (int i = 0; i < 300; i++) begin
      rd(3'h0, st);
      rd(3'h2, md);
      if (st[1] === 1'b0 && md[7] === 1'b0)
        return;
    end
    tmo("idle");
  endtask

  // Timing is only rewritten while disabled and idle
  task automatic setup(input logic [2:0] cdiv, input logic [2:0] d, input logic ie);
    wr(3'h1, 8'h00);
    wr(3'h3, {2'b00, d, cdiv});
    wr(3'h1, {5'h00, ie, 2'b11});
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    slow = 1'b0;
    irq_d = 1'b0;
    num_errors = 0;
    n_checks = 0;
    n_conv = 0;
    void'($urandom(80));
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00, "reset reg");
    setup(3'h0, 3'h0, 1'b1);
    chk("power", 8'h03, {6'h00, o_ref_power, o_core_power});
    $display("test reset done");
    // Mode bits only change while idle; each setup powers the converter down and up again before the start
    for (int k = 0; k < 2; k++) begin
      dly = (k == 0) ? 3'h0 : 3'($urandom_range(7, 1));
      ch = 3'($urandom);
      setup(3'h0, dly, 1'b1);
      wr(3'h2, {5'h10, ch});
      rchk(3'h0, 8'h32, "status on start");
      waitirq();
      if (k == 0)
        lat0 = int'((t_go - t_wr) / 20);
      else
        chk("delay", 8'(lat0 + int'(dly)), 8'((t_go - t_wr) / 20));
      chk("ticks", 8'(adcsq_pkg::CONV_TICKS), 8'((t_irq - t_go) / 20));
      rchk(3'h0, 8'h01, "status done");
      rchk(3'h2, {5'h00, ch}, "mode done");
      rchk(3'h4, exp_res(ch, n_conv), "result0");
      chk("irq read", 8'h00, {7'h00, o_converter_irq_line});
      rchk(3'h0, 8'h00, "status read");
    end
    $display("test single done");
    for (int k = 0; k < 2; k++) begin
      ch = (k == 0) ? 3'h6 : 3'($urandom);
      setup(3'($urandom_range(2, 0)), 3'($urandom), 1'b1);
      ch_q.delete();
      base = n_conv;
      wr(3'h2, {5'h14, ch});
      waitirq();
      rchk(3'h0, 8'h31, "status scan");
      rchk(3'h2, {5'h04, ch}, "mode scan");
      for (int j = 0; j < 4; j++) begin
        chk("scan chan", {5'h00, nx(ch, j)}, {5'h00, ch_q[j]});
        rchk(3'(4 + j), exp_res(nx(ch, j), base + j + 1), "scan res");
      end
    end
    $display("test scan done");
    setup(3'h0, 3'h0, 1'b1);
    base = n_conv;
    wr(3'h2, {5'h14, ch});
    waitirq();
    wr(3'h2, {5'h10, ch});
    poll_idle();
    rchk(3'h0, 8'h05, "status overrun");
    rchk(3'h4, exp_res(ch, base + 5), "overwritten");
    rchk(3'h5, exp_res(nx(ch, 1), base + 2), "kept");
    wr(3'h0, 8'h00);
    rchk(3'h0, 8'h04, "overrun held");
    wr(3'h0, 8'h04);
    rchk(3'h0, 8'h00, "overrun clear");
    $display("test overrun done");
    slow <= 1'b1;
    ch = 3'($urandom);
    setup(3'h0, 3'($urandom), 1'b1);
    base = n_conv;
    wr(3'h2, {5'h12, ch});
    waitirq();
    rd(3'h0, s);
    chk("repeat status", 8'h31, s & 8'h31);
    for (int j = 0; j < 4; j++) rchk(3'(4 + j), exp_res(ch, base + j + 1), "rep res");
    wr(3'h2, {5'h02, ch});
    poll_idle();
    c = n_conv;
    repeat (60) @(posedge i_clk);
    chk("no restart", 8'(c), 8'(n_conv));
    rd(3'h0, s);
    chk("stop status", {2'b00, 2'(c - base - 1), 4'h1}, s & 8'h33);
    slow <= 1'b0;
    $display("test repeat done");
    ch = 3'($urandom);
    setup(3'h1, 3'($urandom), 1'b1);
    ch_q.delete();
    base = n_conv;
    wr(3'h2, {5'h16, ch});
    waitirq();
    for (int j = 0; j < 4; j++) rchk(3'(4 + j), exp_res(nx(ch, j), base + j + 1), "burst");
    waitirq();
    chk("next burst", {5'h00, ch}, {5'h00, ch_q[4]});
    wr(3'h2, {5'h06, ch});
    poll_idle();
    chk("whole bursts", 8'h00, 8'((n_conv - base) % 4));
    rchk(3'h2, {5'h06, ch}, "mode stopped");
    $display("test burst done");
    // Disabling in mid-conversion on purpose, against the usual stop sequence
    setup(3'h0, 3'h3, 1'b0);
    base = n_conv;
    wr(3'h2, {5'h12, ch});
    for (int i = 0; i < 200 && n_conv == base; i++) @(posedge i_clk);
    if (n_conv == base)
      tmo("start");
    wr(3'h1, 8'h00);
    rd(3'h0, s);
    chk("disabled status", 8'h00, s & 8'h07);
    rchk(3'h2, {5'h02, ch}, "disabled mode");
    c = n_conv;
    repeat (40) @(posedge i_clk);
    chk("aborted", 8'(c), 8'(n_conv));
    chk("power off", 8'h00, {6'h00, o_ref_power, o_core_power});
    setup(3'h0, 3'h0, 1'b0);
    wr(3'h2, {5'h10, ch});
    poll_idle();
    rchk(3'h0, 8'h01, "eoc masked");
    chk("irq masked", 8'h00, {7'h00, o_converter_irq_line});
    wr(3'h1, 8'h05);
    chk("irq unmasked", 8'h01, {7'h00, o_converter_irq_line});
    $display("test disable done");
    end_of_test();
  end
endmodule
